/* src/tlsp_pkg.sv */
// Package: constants for the temperature limit serial register port
package tlsp_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [2:0]  ADDR_CONFIG     = 3'h1;
	localparam logic [2:0]  ADDR_TEMP       = 3'h2;
	localparam logic [2:0]  ADDR_ID         = 3'h3;
	localparam logic [2:0]  ADDR_CRIT       = 3'h4;
	localparam logic [2:0]  ADDR_HYST       = 3'h5;
	localparam logic [2:0]  ADDR_UPPER      = 3'h6;
	localparam logic [2:0]  ADDR_LOWER      = 3'h7;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] CRIT_RESET      = 16'h4980;
	localparam logic [7:0]  HYST_RESET      = 8'h05;
	localparam logic [15:0] UPPER_RESET     = 16'h2000;
	localparam logic [15:0] LOWER_RESET     = 16'h0500;
	// Arbitrary identity value
	localparam logic [7:0]  ID_VALUE        = 8'h5A;

	// ****************************************
	// Command byte fields
	// ****************************************
	localparam int          CMD_DIR_POS     = 6;
	localparam int          CMD_ADDR_HI     = 5;
	localparam int          CMD_ADDR_LO     = 3;
	localparam int          CMD_BITS        = 8;

	// ****************************************
	// Field layout and timing
	// ****************************************
	localparam int          HYST_WIDTH      = 4;
	localparam int          HYST_FRAC_BITS  = 7;
	localparam int          ONES_RESET_RUN  = 32;
	localparam int          ONES_CNT_WIDTH  = 6;
	localparam int          BIT_CNT_WIDTH   = 5;

	typedef enum logic [1:0]
	{
		ST_CMD  = 2'b00,
		ST_DATA = 2'b01,
		ST_DONE = 2'b11
	} tlsp_state_t;

endpackage

/* src/tlsp_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tlsp_sync
	import tlsp_pkg::*;
#(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	typedef struct packed
	{
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} tlsp_sync_t;

	tlsp_sync_t s_reg;
	tlsp_sync_t s_next;

	always_comb
	begin
		s_next.first = pin_in;
		s_next.second = s_reg.first;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s_reg.first <= INIT;
			s_reg.second <= INIT;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign pin_sync = s_reg.second;

endmodule

/* src/tlsp_port.sv */
// Serial register port with limit setpoints and alert outputs
// ****************************************
// What this block does
// - Direction bit one reads, zero writes
// - Address bits pick one register per transaction
// - Sample on rising, shift out on falling
// - Write shifts 8 or 16 bits in
// - Read drives register from first falling edge
// - Frame sync: select fall presents output MSB
// - Select tied low works as 3-wire
// - 32 ones on data resets port
// - Serial reset restores register defaults
// - Hysteresis: four low bits, reset five
// - Hysteresis lowers critical; in comparator mode also lowers upper, raises lower
// - Above upper limit asserts limit alert
// - Critical limit 16 bits, reset 0x4980
// - Upper limit 16 bits, reset 0x2000
// - Below lower limit asserts limit alert
// - Lower limit 16 bits, reset 0x0500
// - Above critical asserts critical alert
// - Interrupt mode: register read clears alert
// ****************************************
`timescale 1ns/1ps
module tlsp_port
	import tlsp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe_n,
	input  wire logic [15:0] temp_value,
	input  wire logic        interrupt_mode,
	output logic             limit_alert_o,
	output logic             limit_alert_oe_n,
	output logic             critical_alert_output,
	output logic             critical_alert_oe_n,
	output logic             over_flag,
	output logic             under_flag
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		tlsp_state_t               state;
		logic                      sclk_d;
		logic                      cs_n_d;
		logic [7:0]                cmd;
		logic [BIT_CNT_WIDTH-1:0]  bit_cnt;
		logic [15:0]               shift;
		logic [ONES_CNT_WIDTH-1:0] ones_cnt;
		logic                      dout;
		logic                      drive;
		logic [15:0]               crit;
		logic [7:0]                hyst;
		logic [15:0]               upper;
		logic [15:0]               lower;
		logic                      limit_alert;
		logic                      crit_alert;
		logic                      over;
		logic                      under;
		logic                      crit_over;
	} tlsp_port_t;

	tlsp_port_t s_reg;
	tlsp_port_t s_next;

	logic [2:0] pins_sync;
	logic       sclk_s;
	logic       cs_n_s;
	logic       din_s;

	tlsp_sync #(
		.WIDTH (3),
		.INIT  (3'h6)
	) u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.pin_in   ({sclk, cs_n, din}),
		.pin_sync (pins_sync)
	);

	assign sclk_s = pins_sync[2];
	assign cs_n_s = pins_sync[1];
	assign din_s  = pins_sync[0];

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [4:0] reg_width(input logic [2:0] addr);
		if (addr == ADDR_HYST || addr == ADDR_ID || addr == ADDR_CONFIG)
			reg_width = 5'd8;
		else
			reg_width = 5'd16;
	endfunction

	function automatic logic signed [17:0] sx(input logic [15:0] v);
		sx = 18'(signed'(v));
	endfunction

	// ****************************************
	// Command decoding
	// ****************************************
	function automatic logic [2:0] cmd_addr(input logic [7:0] c);
		cmd_addr = c[CMD_ADDR_HI:CMD_ADDR_LO];
	endfunction

	function automatic logic cmd_read(input logic [7:0] c);
		cmd_read = c[CMD_DIR_POS];
	endfunction

	function automatic logic signed [17:0] hyst_scaled(input logic [7:0] h);
		logic [17:0] v;
		v = '0;
		v[HYST_FRAC_BITS +: HYST_WIDTH] = h[HYST_WIDTH-1:0];
		hyst_scaled = signed'(v);
	endfunction

	function automatic tlsp_port_t load_defaults(input tlsp_port_t s);
		load_defaults = s;
		load_defaults.crit = CRIT_RESET;
		load_defaults.hyst = HYST_RESET;
		load_defaults.upper = UPPER_RESET;
		load_defaults.lower = LOWER_RESET;
	endfunction

	function automatic tlsp_port_t store_write(input tlsp_port_t s, input logic [2:0] a, input logic [15:0] v);
		store_write = s;
		if (a == ADDR_CRIT)
			store_write.crit = v;
		else if (a == ADDR_UPPER)
			store_write.upper = v;
		else if (a == ADDR_LOWER)
			store_write.lower = v;
		else if (a == ADDR_HYST)
			store_write.hyst = {4'h0, v[HYST_WIDTH-1:0]};
		// Other addresses are read-only: data dropped
	endfunction

	function automatic logic [15:0] read_value(input tlsp_port_t s, input logic [2:0] addr);
		if (addr == ADDR_CRIT)
			read_value = s.crit;
		else if (addr == ADDR_HYST)
			read_value = {s.hyst, 8'h00};
		else if (addr == ADDR_UPPER)
			read_value = s.upper;
		else if (addr == ADDR_LOWER)
			read_value = s.lower;
		else if (addr == ADDR_TEMP)
			read_value = temp_value;
		else if (addr == ADDR_ID)
			read_value = {ID_VALUE, 8'h00};
		else
			read_value = 16'h0000;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	logic                 rise;
	logic                 fall;
	logic                 cs_fall;
	logic [2:0]           addr;
	logic [7:0]           cmd_new;
	logic [4:0]           width;
	logic [15:0]          rdata;
	logic [15:0]          wdata;
	logic                 ones_full;
	logic                 reg_read;
	logic signed [17:0]   t_s;
	logic signed [17:0]   hyst_s;

	always_comb
	begin
		s_next = s_reg;
		s_next.sclk_d = sclk_s;
		s_next.cs_n_d = cs_n_s;
		rise = sclk_s && !s_reg.sclk_d && !cs_n_s;
		fall = !sclk_s && s_reg.sclk_d && !cs_n_s;
		cs_fall = !cs_n_s && s_reg.cs_n_d;
		addr = cmd_addr(s_reg.cmd);
		cmd_new = {s_reg.cmd[6:0], din_s};
		wdata = {s_reg.shift[14:0], din_s};
		width = reg_width(addr);
		rdata = read_value(s_reg, addr);
		reg_read = 1'b0;

		if (cs_n_s)
		begin
			// Select high ends any frame
			s_next.state = ST_CMD;
			s_next.bit_cnt = '0;
			s_next.drive = 1'b0;
		end
		else if (cs_fall)
		begin
			s_next.state = ST_CMD;
			s_next.bit_cnt = '0;
		end

		if (rise)
		begin
			if (din_s)
			begin
				if (s_reg.ones_cnt != ONES_CNT_WIDTH'(ONES_RESET_RUN))
					s_next.ones_cnt = s_reg.ones_cnt + 1'b1;
			end
			else
			begin
				s_next.ones_cnt = '0;
			end
			case (s_reg.state)
				ST_CMD:
				begin
					s_next.cmd = cmd_new;
					s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
					if (s_reg.bit_cnt == BIT_CNT_WIDTH'(CMD_BITS - 1))
					begin
						s_next.bit_cnt = '0;
						s_next.state = ST_DATA;
						s_next.shift = read_value(s_reg, cmd_addr(cmd_new));
						s_next.drive = cmd_read(cmd_new);
						reg_read = cmd_read(cmd_new);
					end
				end
				ST_DATA:
				begin
					// Reads shift here too, so each fall shows the next bit
					s_next.shift = wdata;
					s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
					if (s_reg.bit_cnt == width - 1'b1)
					begin
						s_next.state = ST_DONE;
						s_next.drive = 1'b0;
						if (!cmd_read(s_reg.cmd))
							s_next = store_write(s_next, addr, wdata);
						s_next.state = cs_n_s ? ST_CMD : ST_DONE;
						if (s_reg.cs_n_d == 1'b0 && cs_n_s == 1'b0)
							s_next.state = ST_CMD;
						s_next.bit_cnt = '0;
					end
				end
				default:
				begin
					s_next.state = ST_CMD;
				end
			endcase
		end

		if (fall && s_reg.state == ST_DATA && cmd_read(s_reg.cmd))
		begin
			s_next.dout = s_reg.shift[15];
		end
		else if (cs_fall)
		begin
			s_next.dout = s_reg.shift[15];
		end

		// Long run of ones restores the port and registers
		ones_full = s_next.ones_cnt == ONES_CNT_WIDTH'(ONES_RESET_RUN);
		if (ones_full)
		begin
			s_next = load_defaults(s_next);
			s_next.state = ST_CMD;
			s_next.bit_cnt = '0;
			s_next.cmd = '0;
			s_next.drive = 1'b0;
			s_next.ones_cnt = '0;
		end

		// Limit comparisons with hysteresis, in 1 degree steps
		t_s = sx(temp_value);
		hyst_s = hyst_scaled(s_reg.hyst);
		s_next.over = t_s > sx(s_reg.upper);
		s_next.under = t_s < sx(s_reg.lower);
		if (t_s > sx(s_reg.crit))
			s_next.crit_over = 1'b1;
		else if (t_s < sx(s_reg.crit) - hyst_s)
			s_next.crit_over = 1'b0;
		s_next.crit_alert = s_next.crit_over;

		if (interrupt_mode)
		begin
			if ((s_next.over && !s_reg.over) || (s_next.under && !s_reg.under))
				s_next.limit_alert = 1'b1;
			else if (reg_read)
				s_next.limit_alert = 1'b0;
		end
		else
		begin
			if (s_next.over || s_next.under)
				s_next.limit_alert = 1'b1;
			else if (t_s < sx(s_reg.upper) - hyst_s && t_s > sx(s_reg.lower) + hyst_s)
				s_next.limit_alert = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s_reg <= '0;
			s_reg.state <= ST_CMD;
			s_reg.sclk_d <= 1'b1;
			s_reg.cs_n_d <= 1'b1;
			s_reg.crit <= CRIT_RESET;
			s_reg.hyst <= HYST_RESET;
			s_reg.upper <= UPPER_RESET;
			s_reg.lower <= LOWER_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign dout                  = s_reg.dout;
	assign dout_oe_n             = !(s_reg.drive && !cs_n_s);
	assign limit_alert_o         = 1'b0;
	assign limit_alert_oe_n      = !s_reg.limit_alert;
	assign critical_alert_output = s_reg.crit_alert;
	assign critical_alert_oe_n   = !s_reg.crit_alert;
	assign over_flag             = s_reg.over;
	assign under_flag            = s_reg.under;

endmodule

/* tb/tlsp_chk.sv */
// Checker for the serial port and alert outputs
`timescale 1ns/1ps
// *****
// Checker
// *****
module tlsp_chk
	import tlsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic interrupt_mode,
	input wire logic limit_alert_o,
	input wire logic limit_alert_oe_n,
	input wire logic critical_alert_output,
	input wire logic critical_alert_oe_n,
	input wire logic over_flag,
	input wire logic under_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_cs_idle;
		cs_n [*5];
	endsequence
	sequence s_in_data;
		!dout_oe_n && $past(!dout_oe_n) && $changed(dout);
	endsequence
	property p_oe_idle; s_cs_idle |-> dout_oe_n; endproperty
	property p_oe_fall; $fell(dout_oe_n) |-> !cs_n; endproperty
	property p_dout_fall; s_in_data |-> !$past(sclk, 2) || !$past(sclk, 3) || !$past(sclk, 4); endproperty
	property p_lim_zero; limit_alert_o == 1'b0; endproperty
	property p_crit_pair; critical_alert_oe_n == !critical_alert_output; endproperty
	property p_comp_over; !interrupt_mode && over_flag |-> ##[0:2] !limit_alert_oe_n; endproperty
	property p_comp_under; !interrupt_mode && under_flag |-> ##[0:2] !limit_alert_oe_n; endproperty
	// Upper limit kept above lower limit by the bench
	property p_flags_excl; !(over_flag && under_flag); endproperty
	property p_int_set; interrupt_mode && $rose(over_flag) |-> !limit_alert_oe_n; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("dout enabled while deselected");
	a_oe_fall: assert property (p_oe_fall) else $error("dout enabled outside frame");
	a_dout_fall: assert property (p_dout_fall) else $error("dout moved without clock fall");
	a_lim_zero: assert property (p_lim_zero) else $error("limit alert value not low");
	a_crit_pair: assert property (p_crit_pair) else $error("critical pair mismatch");
	a_comp_over: assert property (p_comp_over) else $error("over without alert");
	a_comp_under: assert property (p_comp_under) else $error("under without alert");
	a_flags_excl: assert property (p_flags_excl) else $error("over and under together");
	a_int_set: assert property (p_int_set) else $error("new crossing without alert");
endmodule
bind tlsp_port tlsp_chk tlsp_chk_inst (.core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
	.dout(dout), .dout_oe_n(dout_oe_n), .interrupt_mode(interrupt_mode), .limit_alert_o(limit_alert_o),
	.limit_alert_oe_n(limit_alert_oe_n), .critical_alert_output(critical_alert_output),
	.critical_alert_oe_n(critical_alert_oe_n), .over_flag(over_flag), .under_flag(under_flag));

/* tb/tlsp_master.sv */
// Serial link master model
`timescale 1ns/1ps
// *****
// Master
// *****
module tlsp_master
(
	input  wire logic        core_clk,
	input  wire logic        dout,
	output logic             sclk,
	output logic             cs_n,
	output logic             din,
	output logic             rd_done,
	output logic      [15:0] rd_data
);
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rd_done = 1'b0;
		rd_data = 16'h0000;
	end
	task automatic xfer(input logic [39:0] v, input int n, input logic chk, input logic keep);
		logic [15:0] sh;
		sh = 16'h0000;
		@(posedge core_clk) cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			repeat (4) @(posedge core_clk);
			sclk <= 1'b0;
			din <= v[i];
			repeat (4) @(posedge core_clk);
			sh = {sh[14:0], dout};
			sclk <= 1'b1;
		end
		repeat (4) @(posedge core_clk);
		cs_n <= !keep;
		din <= ~din;
		rd_data <= (n == 24) ? sh : {8'h00, sh[7:0]};
		rd_done <= chk;
		@(posedge core_clk) rd_done <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask
endmodule

/* tb/spi_temp_limit_register_port_tb_top.sv */
// Testbench for the serial register port
`timescale 1ns/1ps
// *****
// Bench
// *****
module spi_temp_limit_register_port_tb_top
	import tlsp_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] temp_value = 16'h1000;
	logic        interrupt_mode = 1'b0;
	logic        sclk, cs_n, din, dout, dout_oe_n, lim_o, lim_oe_n, crit, crit_oe_n, ovr, und, rd_done;
	logic [15:0] rd_data, ev;
	logic [15:0] exp_q[$];
	logic [15:0] dflt[4] = '{CRIT_RESET, {8'h00, HYST_RESET}, UPPER_RESET, LOWER_RESET};
	logic [15:0] wv[4];
	logic [15:0] tv[5] = '{16'h2100, 16'h1F00, 16'h1D00, 16'h0400, 16'h1000};
	logic        ea[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	int          err_total = 0;
	int          cmp_count = 0;
	always #10 core_clk = ~core_clk;
	tlsp_port tlsp_port_inst (.core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe_n(dout_oe_n), .temp_value(temp_value), .interrupt_mode(interrupt_mode),
		.limit_alert_o(lim_o), .limit_alert_oe_n(lim_oe_n), .critical_alert_output(crit),
		.critical_alert_oe_n(crit_oe_n), .over_flag(ovr), .under_flag(und));
	tlsp_master tlsp_master_inst (.core_clk(core_clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din),
		.rd_done(rd_done), .rd_data(rd_data));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_pin(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		err_total += exp_q.size();
		$display("errors=%0d compares=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Command byte with the fixed bits zero
	task automatic acc(input logic rd, input logic [2:0] a, input logic [15:0] d, input logic keep = 1'b0);
		logic [7:0] c;
		c = {1'b0, rd, a, 3'b000};
		if (rd)
			exp_q.push_back(d);
		if (a == ADDR_ID || a == ADDR_HYST)
			tlsp_master_inst.xfer({24'h0, c, d[7:0]}, 16, rd, keep);
		else
			tlsp_master_inst.xfer({16'h0, c, d}, 24, rd, keep);
	endtask
	task automatic settle(input logic [15:0] t);
		@(posedge core_clk) temp_value <= t;
		repeat (6) @(posedge core_clk);
	endtask
	always @(posedge core_clk)
		if (rd_done)
		begin
			ev = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
			cmp(rd_data, ev);
		end
	initial
	begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		end_sim();
	end
	initial
	begin
		void'($urandom(32'h09e564fe));
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		repeat (6) @(posedge core_clk);
		for (int i = 0; i < 4; i++)
			acc(1'b1, ADDR_CRIT + 3'(i), dflt[i]);
		wv = '{16'($urandom), {12'h000, 4'($urandom)}, {2'b01, 14'($urandom)}, {2'b10, 14'($urandom)}};
		for (int i = 0; i < 4; i++)
			acc(1'b0, ADDR_CRIT + 3'(i), wv[i]);
		for (int i = 0; i < 4; i++)
			acc(1'b1, ADDR_CRIT + 3'(i), wv[i]);
		acc(1'b0, ADDR_ID, 16'($urandom));
		acc(1'b1, ADDR_ID, {8'h00, ID_VALUE});
		@(posedge core_clk) temp_value <= 16'($urandom);
		repeat (4) @(posedge core_clk);
		acc(1'b1, ADDR_TEMP, temp_value);
		tlsp_master_inst.xfer({40{1'b1}}, 32, 1'b0, 1'b0);
		repeat (25000) @(posedge core_clk);
		for (int i = 0; i < 4; i++)
			acc(1'b1, ADDR_CRIT + 3'(i), dflt[i]);
		acc(1'b1, ADDR_UPPER, UPPER_RESET, 1'b1);
		acc(1'b1, ADDR_LOWER, LOWER_RESET);
		for (int i = 0; i < 5; i++)
		begin
			settle(tv[i]);
			cmp_pin(lim_oe_n, ea[i]);
		end
		settle(16'h4A00);
		cmp_pin(crit, 1'b1);
		settle(16'h1000);
		@(posedge core_clk) interrupt_mode <= 1'b1;
		settle(16'h2100);
		cmp_pin(lim_oe_n, 1'b0);
		acc(1'b1, ADDR_UPPER, UPPER_RESET);
		repeat (6) @(posedge core_clk);
		cmp_pin(lim_oe_n, 1'b1);
		repeat (10) @(posedge core_clk);
		end_sim();
	end
endmodule
